// File: bench/rct_scan_model.sv
// scan sequencer stand-in and trigger pulse monitor for the relay trigger bench
`timescale 1ns/10ps
module rct_scan_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // bench controls
  input wire logic fire_in,
  input wire logic clr_in,
  // trigger destinations watched
  input wire logic ext_trig_n_in,
  input wire logic [7:0] bp_n_in,
  // closure strobe and measurements
  output logic scan_close_out,
  output int ext_low_out,
  output int bp_low_out,
  output logic [7:0] bp_seen_out
);
  // one strobe per closure whatever card made it; low cycles are counted, not
  // edges, so a pulse that is too long or too short shows up as a wrong total
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      scan_close_out <= 1'h0;
      ext_low_out <= 0;
      bp_low_out <= 0;
      bp_seen_out <= 8'h00;
    end else begin
      scan_close_out <= fire_in;
      if (clr_in) begin
        ext_low_out <= 0;
        bp_low_out <= 0;
        bp_seen_out <= 8'h00;
      end else begin
        ext_low_out <= ext_low_out + int'(!ext_trig_n_in);
        bp_low_out <= bp_low_out + $countones(~bp_n_in);
        bp_seen_out <= bp_seen_out | ~bp_n_in;
      end
    end
  end
endmodule

// File: bench/tb.sv
// self-checking bench for the relay channel trigger block
`timescale 1ns/10ps
module tb import rct_pkg::*; ;
  logic clk_in, reset_n_in, scan_close_in, ext_trig_n_out, relay_load_out, fire, clr;
  logic [7:0] s_axi_awaddr, s_axi_araddr, backplane_trigger_line_n_out, bp_seen;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  rct_relay_type relay_out, last_relay;
  int fail_count = 0, checks_done = 0, ext_low, bp_low, loads, cyc = 0;

  rct_top rct_top_inst (.clk_in, .reset_n_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .scan_close_in, .ext_trig_n_out, .backplane_trigger_line_n_out,
    .relay_out, .relay_load_out);
  rct_scan_model rct_scan_model_inst (.clk_in, .reset_n_in, .fire_in(fire), .clr_in(clr),
    .ext_trig_n_in(ext_trig_n_out), .bp_n_in(backplane_trigger_line_n_out),
    .scan_close_out(scan_close_in), .ext_low_out(ext_low), .bp_low_out(bp_low),
    .bp_seen_out(bp_seen));

  // 50 MHz clock
  initial begin
    clk_in = 1'h0;
    forever #10 clk_in = ~clk_in;
  end

  // relay word capture; a load is only one cycle wide so it is latched here
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      loads <= 0;
    end else if (relay_load_out) begin
      loads <= loads + 1;
      last_relay <= relay_out;
    end
  end

  // hang guard: the whole run needs under a thousand cycles
  always @(posedge clk_in) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    logic aw, w;
    aw = 1'h0;
    w = 1'h0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw && w)) begin
      @(posedge clk_in);
      if (!aw && s_axi_awready === 1'h1) begin
        aw = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w && s_axi_wready === 1'h1) begin
        w = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge clk_in); while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge clk_in);
  endtask

  task automatic wf(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, 4'hF, resp);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk_in); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk_in); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge clk_in);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, rdat, resp);
    chk($sformatf("reg %h data", a), rdat, e);
    chk($sformatf("reg %h resp", a), resp, RESP_OKAY);
  endtask

  // one closure strobe, then the low time of every destination is judged
  task automatic pulse_check(input int ext_e, input int bp_e, input logic [7:0] seen_e);
    clr <= 1'h1;
    @(posedge clk_in);
    clr <= 1'h0;
    fire <= 1'h1;
    @(posedge clk_in);
    fire <= 1'h0;
    repeat (12) @(posedge clk_in);
    chk("ext low cycles", ext_low, ext_e);
    chk("line low cycles", bp_low, bp_e);
    chk("lines pulsed", bp_seen, seen_e);
    chk("ext back high", ext_trig_n_out, 1'h1);
  endtask

  task automatic do_reset();
    reset_n_in <= 1'h0;
    repeat (5) @(posedge clk_in);
    chk("ext idle", ext_trig_n_out, 1'h1);
    chk("lines idle", backplane_trigger_line_n_out, 8'hFF);
    reset_n_in <= 1'h1;
    @(posedge clk_in);
    rchk(OFF_EXT_EN, 32'h0);
    chk("sweep loads", loads, 100);
    chk("sweep bits", last_relay.bits, 32'h0);
    rchk(OFF_LINE, 32'h0);
    rchk(OFF_PULSE_LEN, 32'h1);
    rchk(OFF_CARD, 32'h1);
    wf(OFF_CARD, 32'h2);
    rchk(OFF_CHAN_STATE, 32'h0);
    pulse_check(0, 0, 8'h00);
  endtask

  task automatic t_ext();
    wr(OFF_EXT_EN, 32'h1, 4'h0, resp);
    rchk(OFF_EXT_EN, 32'h0);
    wf(OFF_EXT_EN, 32'h1);
    rchk(OFF_EXT_EN, 32'h1);
    pulse_check(1, 0, 8'h00);
    wf(OFF_CARD, 32'h63);
    pulse_check(1, 0, 8'h00);
    wf(OFF_PULSE_LEN, 32'h3);
    pulse_check(3, 0, 8'h00);
    wf(OFF_PULSE_LEN, 32'h0);
    pulse_check(1, 0, 8'h00);
    wf(OFF_PULSE_LEN, 32'h1);
    wf(OFF_EXT_EN, 32'h0);
    rchk(OFF_EXT_EN, 32'h0);
    pulse_check(0, 0, 8'h00);
  endtask

  task automatic t_lines();
    wf(OFF_EXT_EN, 32'h1);
    for (int n = 0; n < 8; n++) begin
      wf(OFF_LINE, 32'h100 | n);
      rchk(OFF_LINE, 32'h1 << n);
      rchk(OFF_EXT_EN, 32'h0);
      pulse_check(0, 1, 8'h01 << n);
    end
    wf(OFF_EXT_EN, 32'h1);
    rchk(OFF_LINE, 32'h0);
    wf(OFF_LINE, 32'h103);
    wf(OFF_LINE, 32'h003);
    rchk(OFF_LINE, 32'h0);
    pulse_check(0, 0, 8'h00);
  endtask

  task automatic t_chan();
    wf(OFF_CARD, 32'h2);
    wf(OFF_CLOSE, 32'h8000_0001);
    rchk(OFF_CHAN_STATE, 32'h8000_0001);
    chk("relay card", last_relay.card, 32'h2);
    chk("relay bits", last_relay.bits, 32'h8000_0001);
    wf(OFF_CLOSE, 32'h0000_00F0);
    rchk(OFF_CHAN_STATE, 32'h8000_00F1);
    wf(OFF_OPEN, 32'h0000_0031);
    rchk(OFF_CHAN_STATE, 32'h8000_00C0);
    chk("relay bits", last_relay.bits, 32'h8000_00C0);
    wf(OFF_CARD, 32'h63);
    wf(OFF_CLOSE, 32'hFFFF_FFFF);
    rchk(OFF_CHAN_STATE, 32'hFFFF_FFFF);
    wr(OFF_CARD, 32'h64, 4'hF, resp);
    chk("card range resp", resp, RESP_SLVERR);
    rchk(OFF_CARD, 32'h63);
    wf(OFF_CARD, 32'h2);
    rchk(OFF_CHAN_STATE, 32'h8000_00C0);
    wr(OFF_CHAN_STATE, 32'h0, 4'hF, resp);
    chk("ro write resp", resp, RESP_SLVERR);
    rchk(OFF_CHAN_STATE, 32'h8000_00C0);
    rd(8'h1C, rdat, resp);
    chk("unmapped resp", resp, RESP_SLVERR);
    chk("unmapped data", rdat, 32'h0);
    rd(OFF_CLOSE, rdat, resp);
    chk("wo read resp", resp, RESP_SLVERR);
  endtask

  // main sequence; a second reset after the tests must clear the stored states
  initial begin
    reset_n_in = 1'h0;
    fire = 1'h0;
    clr = 1'h0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'h0;
    s_axi_bready = 1'h0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'h0;
    s_axi_rready = 1'h0;
    @(posedge clk_in);
    do_reset();
    t_ext();
    t_lines();
    t_chan();
    do_reset();
    close_out();
  end
endmodule

// File: design/rct_chan_mem.sv
// stored channel states, one 32-bit word per card, registered read port
`timescale 1ns/10ps
module rct_chan_mem import rct_pkg::*; (
  // clock
  input wire logic clk_in,
  // write port
  input wire logic wr_en_in,
  input wire logic [6:0] wr_addr_in,
  input wire logic [31:0] wr_data_in,
  // read port
  input wire logic [6:0] rd_addr_in,
  output logic [31:0] rd_data_out
);
  logic [31:0] mem_q [0:CARD_MAX];

  // read before write on a shared address; the owner keeps a spare cycle between them
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_q[rd_addr_in];
  end
endmodule

// File: design/rct_pkg.sv
// constants, field layout and carrier types for the relay channel trigger block
// Notes on behaviour
// - enabled external output pulses after each scanned closure; disabled output never pulses.
// - trigger pulses are active low; lines idle high.
// - external output is shared; any card's scanned closure pulses it.
// - at most one destination enabled; enabling another clears the previous one.
// - external output enable is cleared by reset.
// - enable readback gives 1 when enabled, 0 when disabled.
// - 3-bit index picks one of eight backplane lines; enabled line pulses low.
// - disable with a line index clears that line's enable.
// - all backplane line enables are cleared by reset.
// - close sets stored state of all addressed channels and energises relays.
// - open clears stored state of all addressed channels and releases relays.
// - channels of one request may change in any order; host relies on none.
// - state readback gives 1 for stored closed, 0 for open; stored state only.
package rct_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_EXT_EN = 8'h00;
  localparam logic [7:0] OFF_LINE = 8'h04;
  localparam logic [7:0] OFF_PULSE_LEN = 8'h08;
  localparam logic [7:0] OFF_CARD = 8'h0C;
  localparam logic [7:0] OFF_CLOSE = 8'h10;
  localparam logic [7:0] OFF_OPEN = 8'h14;
  localparam logic [7:0] OFF_CHAN_STATE = 8'h18;
  // field positions
  localparam int EXT_EN_BIT = 0;
  localparam int LINE_IDX_LSB = 0;
  localparam int LINE_MODE_BIT = 8;
  // card numbering and reset values
  localparam logic [6:0] CARD_MIN = 7'h01;
  localparam logic [6:0] CARD_MAX = 7'h63;
  localparam logic [6:0] CARD_RST = 7'h01;
  localparam logic [7:0] PULSE_LEN_RST = 8'h01;
  // axi answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {S_INIT, S_IDLE, S_RMW, S_BRESP, S_RRESP} rct_state_type;

  typedef struct packed {
    logic ext_en;
    logic [7:0] bp_en;
  } rct_trig_cfg_type;

  typedef struct packed {
    logic [6:0] card;
    logic [31:0] bits;
  } rct_relay_type;
endpackage

// File: design/rct_top.sv
// relay channel state control with scan-closure trigger output, axi4-lite slave
`timescale 1ns/10ps
module rct_top import rct_pkg::*; (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // axi4-lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // scan sequencer strobe: a scanned channel has just closed
  input wire logic scan_close_in,
  // trigger destinations
  output logic ext_trig_n_out,
  output logic [7:0] backplane_trigger_line_n_out,
  // relay drive update
  output rct_relay_type relay_out,
  output logic relay_load_out
);
  // byte-lane strobes widened to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction
  // a card number is usable only inside 01..99
  function automatic logic card_ok(input logic [31:0] val);
    card_ok = (val[31:7] == 25'h0) && (val[6:0] >= CARD_MIN) && (val[6:0] <= CARD_MAX);
  endfunction

  rct_state_type state_q, state_d;
  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [7:0] aw_addr_q, aw_addr_d, rd_addr_q, rd_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic op_close_q, op_close_d, relay_load_q, relay_load_d, mem_we;
  logic [6:0] init_q, init_d, card_q, card_d, mem_waddr;
  logic [7:0] pulse_len_q, pulse_len_d;
  rct_trig_cfg_type trig_q, trig_d;
  rct_relay_type relay_q, relay_d;
  logic [31:0] mem_wdata, mem_rdata, wr_data;
  logic aw_fire, w_fire, ar_fire, wr_go;
  assign aw_fire = s_axi_awvalid && awready_q;
  assign w_fire = s_axi_wvalid && wready_q;
  assign ar_fire = s_axi_arvalid && arready_q;
  assign wr_go = (state_q == S_IDLE) && aw_held_q && w_held_q;
  assign wr_data = w_data_q & strb_mask(w_strb_q);
  rct_chan_mem u_mem (
    .clk_in(clk_in),
    .wr_en_in(mem_we),
    .wr_addr_in(mem_waddr),
    .wr_data_in(mem_wdata),
    .rd_addr_in(card_q),
    .rd_data_out(mem_rdata)
  );

  // bus slave, register file and channel state sequencing
  always_comb begin
    state_d = state_q;
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    aw_addr_d = aw_addr_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    rd_addr_d = rd_addr_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    op_close_d = op_close_q;
    init_d = init_q;
    card_d = card_q;
    pulse_len_d = pulse_len_q;
    trig_d = trig_q;
    relay_d = relay_q;
    relay_load_d = 1'b0;
    mem_we = 1'b0;
    mem_waddr = card_q;
    mem_wdata = 32'h0000_0000;
    if (aw_fire) begin
      aw_held_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (w_fire) begin
      w_held_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    case (state_q)
      S_INIT: begin
        // sweep every card word to open and drive the relays released
        mem_we = 1'b1;
        mem_waddr = init_q;
        relay_d = '{card: init_q, bits: 32'h0000_0000};
        relay_load_d = 1'b1;
        if (init_q == CARD_MAX) begin
          state_d = S_IDLE;
        end else begin
          init_d = init_q + 7'h01;
        end
      end
      S_IDLE: begin
        if (aw_held_q && w_held_q) begin
          aw_held_d = 1'b0;
          w_held_d = 1'b0;
          bvalid_d = 1'b1;
          bresp_d = RESP_OKAY;
          state_d = S_BRESP;
          case (aw_addr_q)
            OFF_EXT_EN: begin
              if (w_strb_q[0]) begin
                trig_d.ext_en = wr_data[EXT_EN_BIT];
                trig_d.bp_en = wr_data[EXT_EN_BIT] ? 8'h00 : trig_q.bp_en;
              end
            end
            OFF_LINE: begin
              if (w_strb_q[1] && wr_data[LINE_MODE_BIT]) begin
                trig_d.bp_en = 8'h01 << wr_data[LINE_IDX_LSB +: 3];
                trig_d.ext_en = 1'b0;
              end else if (w_strb_q[1]) begin
                trig_d.bp_en[wr_data[LINE_IDX_LSB +: 3]] = 1'b0;
              end
            end
            OFF_PULSE_LEN: begin
              if (w_strb_q[0]) begin
                pulse_len_d = wr_data[7:0];
              end
            end
            OFF_CARD: begin
              // out-of-range cards are refused so the memory index stays valid
              if (card_ok(wr_data)) begin
                card_d = wr_data[6:0];
              end else begin
                bresp_d = RESP_SLVERR;
              end
            end
            OFF_CLOSE, OFF_OPEN: begin
              bvalid_d = 1'b0;
              op_close_d = (aw_addr_q == OFF_CLOSE);
              state_d = S_RMW;
            end
            default: bresp_d = RESP_SLVERR;
          endcase
        end else if (ar_fire) begin
          rvalid_d = 1'b1;
          rresp_d = RESP_OKAY;
          rd_addr_d = s_axi_araddr;
          state_d = S_RRESP;
          case (s_axi_araddr)
            OFF_EXT_EN: rdata_d = {31'h0000_0000, trig_q.ext_en};
            OFF_LINE: rdata_d = {24'h00_0000, trig_q.bp_en};
            OFF_PULSE_LEN: rdata_d = {24'h00_0000, pulse_len_q};
            OFF_CARD: rdata_d = {25'h000_0000, card_q};
            OFF_CHAN_STATE: rdata_d = mem_rdata;
            default: begin
              rdata_d = 32'h0000_0000;
              rresp_d = RESP_SLVERR;
            end
          endcase
        end
      end
      S_RMW: begin
        // every masked channel of the card changes in the same cycle; close ors, open clears
        mem_we = 1'b1;
        mem_wdata = op_close_q ? (mem_rdata | wr_data) : (mem_rdata & ~wr_data);
        relay_d = '{card: card_q, bits: mem_wdata};
        relay_load_d = 1'b1;
        bvalid_d = 1'b1;
        bresp_d = RESP_OKAY;
        state_d = S_BRESP;
      end
      S_BRESP: begin
        if (s_axi_bready) begin
          bvalid_d = 1'b0;
          state_d = S_IDLE;
        end
      end
      S_RRESP: begin
        if (s_axi_rready) begin
          rvalid_d = 1'b0;
          state_d = S_IDLE;
        end
      end
      default: state_d = S_IDLE;
    endcase
    awready_d = (state_d != S_INIT) && !aw_held_d;
    wready_d = (state_d != S_INIT) && !w_held_d;
    arready_d = (state_d == S_IDLE) && !(aw_held_d && w_held_d);
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= S_INIT;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      rd_addr_q <= 8'h00;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      op_close_q <= 1'b0;
      init_q <= 7'h00;
      card_q <= CARD_RST;
      pulse_len_q <= PULSE_LEN_RST;
      trig_q <= '0;
      relay_q <= '0;
      relay_load_q <= 1'b0;
    end else begin
      state_q <= state_d;
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      aw_addr_q <= aw_addr_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      rd_addr_q <= rd_addr_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      arready_q <= arready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      op_close_q <= op_close_d;
      init_q <= init_d;
      card_q <= card_d;
      pulse_len_q <= pulse_len_d;
      trig_q <= trig_d;
      relay_q <= relay_d;
      relay_load_q <= relay_load_d;
    end
  end

  // trigger pulse timer; destination is latched so a mid-pulse reconfigure cannot split it
  logic [7:0] cnt_q, cnt_d, dest_bp_q, dest_bp_d, bp_n_q, bp_n_d;
  logic dest_ext_q, dest_ext_d, ext_n_q, ext_n_d;
  always_comb begin
    cnt_d = cnt_q;
    dest_ext_d = dest_ext_q;
    dest_bp_d = dest_bp_q;
    // a closure from any card restarts the pulse on the shared destination
    if (scan_close_in && (trig_q.ext_en || (trig_q.bp_en != 8'h00))) begin
      cnt_d = (pulse_len_q == 8'h00) ? 8'h01 : pulse_len_q;
      dest_ext_d = trig_q.ext_en;
      dest_bp_d = trig_q.bp_en;
    end else if (cnt_q != 8'h00) begin
      cnt_d = cnt_q - 8'h01;
    end
    ext_n_d = !((cnt_d != 8'h00) && dest_ext_d);
    bp_n_d = ~(dest_bp_d & {8{cnt_d != 8'h00}});
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_q <= 8'h00;
      dest_ext_q <= 1'b0;
      dest_bp_q <= 8'h00;
      ext_n_q <= 1'b1;
      bp_n_q <= 8'hFF;
    end else begin
      cnt_q <= cnt_d;
      dest_ext_q <= dest_ext_d;
      dest_bp_q <= dest_bp_d;
      ext_n_q <= ext_n_d;
      bp_n_q <= bp_n_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_arready = arready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign ext_trig_n_out = ext_n_q;
  assign backplane_trigger_line_n_out = bp_n_q;
  assign relay_out = relay_q;
  assign relay_load_out = relay_load_q;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  one_destination_a: assert property ($onehot0({trig_q.ext_en, trig_q.bp_en}))
    else $error("more than one trigger destination enabled");
  ext_pulse_a: assert property (scan_close_in && trig_q.ext_en |=> !ext_trig_n_out)
    else $error("no external pulse after scanned closure");
  idle_high_a: assert property (!scan_close_in && cnt_q == 8'h00 |=>
    ext_trig_n_out && (backplane_trigger_line_n_out == 8'hFF))
    else $error("trigger line low with no pulse running");
  pulse_width_a: assert property (scan_close_in && trig_q.ext_en && pulse_len_q == 8'h01
    ##1 !scan_close_in |-> !ext_trig_n_out ##1 ext_trig_n_out)
    else $error("one-cycle pulse has wrong width");
  line_select_a: assert property (scan_close_in && trig_q.bp_en != 8'h00 |=>
    backplane_trigger_line_n_out == ~$past(trig_q.bp_en))
    else $error("wrong backplane line pulsed");
  line_disable_a: assert property (wr_go && aw_addr_q == OFF_LINE && w_strb_q[1]
    && !wr_data[LINE_MODE_BIT] |=> !trig_q.bp_en[$past(wr_data[2:0])])
    else $error("backplane line still enabled after disable");
  ext_readback_a: assert property (s_axi_rvalid && rd_addr_q == OFF_EXT_EN |->
    s_axi_rdata == {31'h0000_0000, trig_q.ext_en})
    else $error("external enable readback mismatch");
  close_apply_a: assert property (state_q == S_RMW && op_close_q |=>
    relay_load_out && ((relay_out.bits & $past(wr_data)) == $past(wr_data)))
    else $error("closed channels not set in relay drive");
  open_apply_a: assert property (state_q == S_RMW && !op_close_q |=>
    relay_load_out && ((relay_out.bits & $past(wr_data)) == 32'h0000_0000))
    else $error("opened channels still set in relay drive");
  init_clear_a: assert property (state_q == S_INIT |=>
    relay_load_out && relay_out.bits == 32'h0000_0000)
    else $error("relay drive not cleared during start-up sweep");
endmodule
